// *** inc/sram_mmu_consts.svh ***
`ifndef SRAM_MMU_CONSTS_SVH
`define SRAM_MMU_CONSTS_SVH

// bank geometry
`define MMU_PAGES 16
`define WIN_LSB 17
`define CODE_BASE 32'h40080000
`define DATA_BASE 32'h3FFC0000

// page size select codes and the matching page shifts
`define SEL_8K 2'h0
`define SEL_4K 2'h1
`define SEL_2K 2'h2
`define SEL_BAD 2'h3
`define PG_SHIFT_8K 4'hD
`define PG_SHIFT_4K 4'hC
`define PG_SHIFT_2K 4'hB

// table entry layout
`define ENT_W 7
`define RIGHTS_NONE 3'h0
`define RIGHTS_ALL 3'h1
`define PID_PRIV_MAX 3'h1

// register byte offsets
`define REG_CODE_TBL 8'h00
`define REG_DATA_TBL 8'h40
`define REG_CODE_PSEL 8'h80
`define REG_DATA_PSEL 8'h84
`define REG_DENY_STAT 8'h88

// reset values
`define RST_ENTRY 7'h00
`define RST_PSEL 2'h0

`endif

// *** inc/sram_mmu_pkg.sv ***
package sram_mmu_pkg;
  // one page map table entry
  typedef struct packed {
    logic [2:0] rights; // process admission code
    logic [3:0] vpage;  // virtual page steered here
  } map_entry_s;
  // page size selector value
  typedef logic [1:0] page_sel_t;
  // process identifier
  typedef logic [2:0] pid_t;
endpackage : sram_mmu_pkg

// *** inc/xlat_if.sv ***
`timescale 1ns/10ps
interface xlat_if;
  import sram_mmu_pkg::*;
  // access under inspection
  logic [31:0] addr;
  pid_t process_identifier;
  logic write;
  // bank configuration
  page_sel_t page_sel;
  map_entry_s tbl [16];
  // verdict
  logic [31:0] phys_addr;
  logic allow;
  // translation unit side
  modport unit (input addr, input process_identifier, input write, input page_sel, input tbl,
                output phys_addr, output allow);
  // bank pipeline side
  modport ctrl (output addr, output process_identifier, output write, output page_sel, output tbl,
                input phys_addr, input allow);
endinterface : xlat_if

// *** verilog/page_xlat_unit.sv ***
`timescale 1ns/10ps
`include "sram_mmu_consts.svh"
module page_xlat_unit
  import sram_mmu_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = `CODE_BASE,
  parameter bit WRITE_OK = 1'b1
) (
  // access and verdict
  xlat_if.unit xif
);
  logic [16:0] offs;      // offset inside the 128 KB window
  logic in_win;           // address falls in this bank
  logic [3:0] shift;      // log2 of page size
  logic [3:0] vpage;      // requested virtual page
  logic covered;          // inside the sixteen pages
  logic [16:0] in_mask;   // in-page offset mask
  logic [15:0] match;     // per physical page hit
  logic hit;              // some page admits the access
  logic [3:0] ppage;      // chosen physical page
  logic priv;             // process 0 or 1

  assign offs = xif.addr[`WIN_LSB-1:0];
  assign in_win = (xif.addr[31:`WIN_LSB] == BASE_ADDR[31:`WIN_LSB]);
  assign priv = (xif.process_identifier <= `PID_PRIV_MAX);

  // page size decode; an illegal code falls back to the largest page
  always_comb begin
    unique case (xif.page_sel)
      `SEL_4K: shift = `PG_SHIFT_4K;
      `SEL_2K: shift = `PG_SHIFT_2K;
      default: shift = `PG_SHIFT_8K;
    endcase
  end

  // sixteen pages whatever the size, the rest is tail
  assign vpage = 4'(offs >> shift);
  assign covered = ((offs >> shift) < 17'(`MMU_PAGES));
  assign in_mask = 17'((17'h1 << shift) - 17'h1);

  // each entry describes its own physical page
  for (genvar p = 0; p < `MMU_PAGES; p++) begin : g_match
    assign match[p] = (xif.tbl[p].vpage == vpage)
      && ((xif.tbl[p].rights == `RIGHTS_ALL) || (xif.tbl[p].rights == xif.process_identifier));
  end

  // lowest matching physical page wins, scan top down
  always_comb begin
    ppage = 4'h0;
    for (int p = `MMU_PAGES - 1; p >= 0; p--) begin
      if (match[p]) begin
        ppage = 4'(p);
      end
    end
  end
  assign hit = |match;

  // verdict and physical address
  always_comb begin
    if (priv) begin
      xif.allow = in_win;
      xif.phys_addr = xif.addr;
    end else begin
      xif.allow = in_win && covered && hit && (WRITE_OK || !xif.write);
      xif.phys_addr = {BASE_ADDR[31:`WIN_LSB],
        17'((17'(ppage) << shift) | (offs & in_mask))};
    end
  end
endmodule : page_xlat_unit

// *** verilog/internal_sram_page_mmu.sv ***
`timescale 1ns/10ps
`include "sram_mmu_consts.svh"
module internal_sram_page_mmu
  import sram_mmu_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_pid,
  output logic [31:0] reg_rdata,
  // instruction bus access, code bank
  input wire logic ibus_valid,
  input wire logic [31:0] ibus_addr,
  input wire logic ibus_write,
  input wire logic [DATA_W-1:0] ibus_wdata,
  input wire logic [2:0] ibus_pid,
  // instruction bus response
  output logic ibus_rsp_valid,
  output logic [DATA_W-1:0] ibus_rsp_rdata,
  output logic ibus_rsp_deny,
  // code sram bank port
  output logic code_mem_req,
  output logic code_mem_we,
  output logic [31:0] code_mem_addr,
  output logic [DATA_W-1:0] code_mem_wdata,
  input wire logic [DATA_W-1:0] code_mem_rdata,
  // data bus access, data bank
  input wire logic dbus_valid,
  input wire logic [31:0] dbus_addr,
  input wire logic dbus_write,
  input wire logic [DATA_W-1:0] dbus_wdata,
  input wire logic [2:0] dbus_pid,
  // data bus response
  output logic dbus_rsp_valid,
  output logic [DATA_W-1:0] dbus_rsp_rdata,
  output logic dbus_rsp_deny,
  // data sram bank port
  output logic data_mem_req,
  output logic data_mem_we,
  output logic [31:0] data_mem_addr,
  output logic [DATA_W-1:0] data_mem_wdata,
  input wire logic [DATA_W-1:0] data_mem_rdata
);
  // bank 0 is the code bank, bank 1 the data bank
  localparam int BANKS = 2;

  // per bank view of the bus inputs
  logic acc_valid [BANKS];
  logic [31:0] acc_addr [BANKS];
  logic acc_write [BANKS];
  logic [DATA_W-1:0] acc_wdata [BANKS];
  pid_t acc_pid [BANKS];
  logic [DATA_W-1:0] mem_rdata [BANKS];

  // configuration storage
  map_entry_s tbl_reg [BANKS][16];  // page map tables
  page_sel_t psel_reg [BANKS];      // page size selectors
  logic [BANKS-1:0] deny_stat_reg;  // sticky denial flags
  logic [BANKS-1:0] deny_set;       // denial seen this cycle

  // memory side stage
  logic mem_req_reg [BANKS];
  logic mem_we_reg [BANKS];
  logic [31:0] mem_addr_reg [BANKS];
  logic [DATA_W-1:0] mem_wdata_reg [BANKS];
  logic pend_reg [BANKS];           // response due next cycle
  logic pend_rd_reg [BANKS];        // that response carries read data
  logic pend_deny_reg [BANKS];      // that access was blocked

  // response stage
  logic rsp_valid_reg [BANKS];
  logic [DATA_W-1:0] rsp_rdata_reg [BANKS];
  logic rsp_deny_reg [BANKS];

  // register port
  logic [31:0] reg_rdata_reg;
  logic [31:0] reg_rdata_next;
  logic cfg_wr_ok;                  // writer is a privileged process
  logic tbl_hit;                    // address inside a table
  logic tbl_bank;                   // which table
  logic [3:0] tbl_idx;              // which entry

  // the code unit hangs on the instruction bus, the data unit on the data bus
  assign acc_valid[0] = ibus_valid;
  assign acc_addr[0] = ibus_addr;
  assign acc_write[0] = ibus_write;
  assign acc_wdata[0] = ibus_wdata;
  assign acc_pid[0] = ibus_pid;
  assign mem_rdata[0] = code_mem_rdata;
  assign acc_valid[1] = dbus_valid;
  assign acc_addr[1] = dbus_addr;
  assign acc_write[1] = dbus_write;
  assign acc_wdata[1] = dbus_wdata;
  assign acc_pid[1] = dbus_pid;
  assign mem_rdata[1] = data_mem_rdata;

  // outputs straight from the pipeline flops
  assign code_mem_req = mem_req_reg[0];
  assign code_mem_we = mem_we_reg[0];
  assign code_mem_addr = mem_addr_reg[0];
  assign code_mem_wdata = mem_wdata_reg[0];
  assign ibus_rsp_valid = rsp_valid_reg[0];
  assign ibus_rsp_rdata = rsp_rdata_reg[0];
  assign ibus_rsp_deny = rsp_deny_reg[0];
  assign data_mem_req = mem_req_reg[1];
  assign data_mem_we = mem_we_reg[1];
  assign data_mem_addr = mem_addr_reg[1];
  assign data_mem_wdata = mem_wdata_reg[1];
  assign dbus_rsp_valid = rsp_valid_reg[1];
  assign dbus_rsp_rdata = rsp_rdata_reg[1];
  assign dbus_rsp_deny = rsp_deny_reg[1];
  assign reg_rdata = reg_rdata_reg;

  // register address decode shared by both banks
  assign cfg_wr_ok = reg_wr && (reg_pid <= `PID_PRIV_MAX);
  assign tbl_hit = (reg_addr[7] == 1'b0) && (reg_addr[1:0] == 2'h0);
  assign tbl_bank = reg_addr[6];
  assign tbl_idx = reg_addr[5:2];

  // one translation unit and one pipeline per bank
  for (genvar g = 0; g < BANKS; g++) begin : g_bank
    xlat_if xif ();
    logic cfg_psel_hit;             // write aimed at this selector

    // feed the unit with the live access and configuration
    assign xif.addr = acc_addr[g];
    assign xif.process_identifier = acc_pid[g];
    assign xif.write = acc_write[g];
    assign xif.page_sel = psel_reg[g];
    assign xif.tbl = tbl_reg[g];
    assign deny_set[g] = ce && acc_valid[g] && !xif.allow;
    assign cfg_psel_hit = (reg_addr == ((g == 0) ? `REG_CODE_PSEL : `REG_DATA_PSEL));

    // only the data unit lets ordinary processes write
    page_xlat_unit #(
      .BASE_ADDR((g == 0) ? `CODE_BASE : `DATA_BASE),
      .WRITE_OK(g == 1)
    ) u_xlat (
      .xif(xif.unit)
    );

    // page map table of this bank
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        for (int p = 0; p < 16; p++) begin
          tbl_reg[g][p] <= map_entry_s'(`RST_ENTRY);
        end
      end else if (ce) begin
        // unprivileged writers are silently dropped
        if (cfg_wr_ok && tbl_hit && (tbl_bank == 1'(g))) begin
          tbl_reg[g][tbl_idx] <= map_entry_s'(reg_wdata[`ENT_W-1:0]);
        end
      end
    end

    // page size selector of this bank
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        psel_reg[g] <= `RST_PSEL;
      end else if (ce) begin
        // the undefined code is refused so the unit never sees it
        if (cfg_wr_ok && cfg_psel_hit && (reg_wdata[1:0] != `SEL_BAD)) begin
          psel_reg[g] <= reg_wdata[1:0];
        end
      end
    end

    // memory request stage; a blocked access never reaches the bank
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        mem_req_reg[g] <= 1'b0;
        mem_we_reg[g] <= 1'b0;
        mem_addr_reg[g] <= 32'h00000000;
        mem_wdata_reg[g] <= '0;
        pend_reg[g] <= 1'b0;
        pend_rd_reg[g] <= 1'b0;
        pend_deny_reg[g] <= 1'b0;
      end else if (ce) begin
        mem_req_reg[g] <= acc_valid[g] && xif.allow;
        mem_we_reg[g] <= acc_valid[g] && xif.allow && acc_write[g];
        // address and data held when idle to save toggling
        if (acc_valid[g]) begin
          mem_addr_reg[g] <= xif.phys_addr;
          mem_wdata_reg[g] <= acc_wdata[g];
        end
        pend_reg[g] <= acc_valid[g];
        pend_rd_reg[g] <= acc_valid[g] && !acc_write[g];
        pend_deny_reg[g] <= acc_valid[g] && !xif.allow;
      end
    end

    // response stage, one cycle after the bank saw the request
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        rsp_valid_reg[g] <= 1'b0;
        rsp_rdata_reg[g] <= '0;
        rsp_deny_reg[g] <= 1'b0;
      end else if (ce) begin
        rsp_valid_reg[g] <= pend_reg[g];
        rsp_deny_reg[g] <= pend_reg[g] && pend_deny_reg[g];
        // blocked reads and writes return zero, never stale bank data
        if (pend_rd_reg[g] && !pend_deny_reg[g]) begin
          rsp_rdata_reg[g] <= mem_rdata[g];
        end else begin
          rsp_rdata_reg[g] <= '0;
        end
      end
    end
  end

  // sticky denial flags; write one to clear, a new denial wins the tie
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      deny_stat_reg <= '0;
    end else if (ce) begin
      if (reg_wr && (reg_addr == `REG_DENY_STAT)) begin
        deny_stat_reg <= (deny_stat_reg & ~reg_wdata[BANKS-1:0]) | deny_set;
      end else begin
        deny_stat_reg <= deny_stat_reg | deny_set;
      end
    end
  end

  // read mux; any process may read the configuration back
  always_comb begin
    reg_rdata_next = 32'h00000000;
    if (tbl_hit) begin
      reg_rdata_next = {25'h0000000, tbl_reg[tbl_bank][tbl_idx]};
    end else begin
      case (reg_addr)
        `REG_CODE_PSEL: reg_rdata_next = {30'h00000000, psel_reg[0]};
        `REG_DATA_PSEL: reg_rdata_next = {30'h00000000, psel_reg[1]};
        `REG_DENY_STAT: reg_rdata_next = {30'h00000000, deny_stat_reg};
        // unmapped addresses read as zero
        default: reg_rdata_next = 32'h00000000;
      endcase
    end
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_reg <= 32'h00000000;
    end else if (ce) begin
      if (reg_rd) begin
        reg_rdata_reg <= reg_rdata_next;
      end else begin
        reg_rdata_reg <= 32'h00000000;
      end
    end
  end
endmodule : internal_sram_page_mmu

// *** dv/sram_mmu_assertions.sv ***
`timescale 1ns/10ps
module sram_mmu_assertions (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // code side
  input wire logic ibus_valid,
  input wire logic ibus_write,
  input wire logic [2:0] ibus_pid,
  input wire logic ibus_rsp_valid,
  input wire logic ibus_rsp_deny,
  // data side
  input wire logic dbus_valid,
  input wire logic [31:0] dbus_addr,
  input wire logic [2:0] dbus_pid,
  input wire logic dbus_rsp_valid,
  input wire logic [31:0] dbus_rsp_rdata,
  input wire logic dbus_rsp_deny,
  input wire logic data_mem_req,
  input wire logic data_mem_we,
  input wire logic [31:0] data_mem_addr,
  input wire logic [31:0] data_mem_rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // data access taken at this edge
  sequence s_dacc;
    ce && dbus_valid;
  endsequence
  // data access inside the governed window
  sequence s_dwin;
    s_dacc ##0 (dbus_addr >= 32'h3FFC0000 && dbus_addr <= 32'h3FFDFFFF);
  endsequence
  // every access is answered two cycles later, allowed or not
  property p_dacc_rsp; s_dacc ##1 ce |=> dbus_rsp_valid; endproperty
  property p_iacc_rsp; ce && ibus_valid ##1 ce |=> ibus_rsp_valid; endproperty
  // privileged processes keep their address, no table lookup
  property p_priv;
    s_dwin ##0 dbus_pid <= 3'h1 |=> data_mem_req && data_mem_addr == $past(dbus_addr);
  endproperty
  // outside the window nothing reaches the bank
  property p_outwin;
    s_dacc ##0 !(dbus_addr >= 32'h3FFC0000 && dbus_addr <= 32'h3FFDFFFF) |=> !data_mem_req;
  endproperty
  // smallest page offset always survives translation
  property p_offset;
    s_dacc |=> ((data_mem_addr ^ $past(dbus_addr)) & 32'h000007FF) == 32'h0;
  endproperty
  // code bank is read only for unprivileged processes
  property p_code_wr;
    ce && ibus_valid && ibus_write && ibus_pid > 3'h1 ##1 ce |=> ibus_rsp_deny;
  endproperty
  // blocked access reads as zero
  property p_deny_zero; dbus_rsp_deny |-> dbus_rsp_valid && dbus_rsp_rdata == 32'h0; endproperty
  // a granted read returns exactly the bank word
  property p_req_ok;
    ce && data_mem_req && !data_mem_we |=> !dbus_rsp_deny && dbus_rsp_rdata == $past(data_mem_rdata);
  endproperty
  a_dacc_rsp: assert property (p_dacc_rsp) else $error("data response missing");
  a_iacc_rsp: assert property (p_iacc_rsp) else $error("code response missing");
  a_priv: assert property (p_priv) else $error("privileged access altered");
  a_outwin: assert property (p_outwin) else $error("bank reached outside window");
  a_offset: assert property (p_offset) else $error("page offset changed");
  a_code_wr: assert property (p_code_wr) else $error("code write not blocked");
  a_deny_zero: assert property (p_deny_zero) else $error("denied read not zero");
  a_req_ok: assert property (p_req_ok) else $error("granted read data wrong");
endmodule : sram_mmu_assertions

bind internal_sram_page_mmu sram_mmu_assertions u_chk (.clk_sys, .srst, .ce, .ibus_valid,
  .ibus_write, .ibus_pid, .ibus_rsp_valid, .ibus_rsp_deny, .dbus_valid, .dbus_addr, .dbus_pid,
  .dbus_rsp_valid, .dbus_rsp_rdata, .dbus_rsp_deny, .data_mem_req, .data_mem_we,
  .data_mem_addr, .data_mem_rdata);

// *** dv/sram_bank_model.sv ***
`timescale 1ns/10ps
module sram_bank_model (
  // clock
  input wire logic clk_sys,
  // bank port
  input wire logic req,
  input wire logic [31:0] addr,
  output logic [31:0] rdata
);
  // idle pattern, changes every cycle so stale data never looks right
  logic [31:0] idle_reg = 32'h0;
  always_ff @(posedge clk_sys) begin
    idle_reg <= idle_reg + 32'h9E3779B9;
  end
  // read latency folded into the request cycle; word derived from address
  assign rdata = req ? ~addr : idle_reg;
endmodule : sram_bank_model

// *** dv/internal_sram_page_mmu_tb.sv ***
`timescale 1ns/10ps
module internal_sram_page_mmu_tb;
  // clock, reset, enable
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  // register port
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] reg_pid = 3'h0;
  wire [31:0] reg_rdata;
  // access buses, index 0 code, 1 data
  logic [1:0] bvalid = 2'h0;
  logic [1:0] bwrite = 2'h0;
  logic [31:0] baddr [2] = '{2{32'h0}};
  logic [31:0] bwd [2] = '{2{32'h0}};
  logic [2:0] bpid [2] = '{2{3'h0}};
  // responses and bank ports
  wire [1:0] rsp_v, rsp_d, mreq, mwe;
  wire [31:0] rsp_rd [2];
  wire [31:0] maddr [2];
  wire [31:0] mwd [2];
  wire [31:0] mrd [2];
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] ps;
  internal_sram_page_mmu dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_pid(reg_pid),
    .reg_rdata(reg_rdata), .ibus_valid(bvalid[0]), .ibus_addr(baddr[0]),
    .ibus_write(bwrite[0]), .ibus_wdata(bwd[0]), .ibus_pid(bpid[0]),
    .ibus_rsp_valid(rsp_v[0]), .ibus_rsp_rdata(rsp_rd[0]), .ibus_rsp_deny(rsp_d[0]),
    .code_mem_req(mreq[0]), .code_mem_we(mwe[0]), .code_mem_addr(maddr[0]),
    .code_mem_wdata(mwd[0]), .code_mem_rdata(mrd[0]), .dbus_valid(bvalid[1]),
    .dbus_addr(baddr[1]), .dbus_write(bwrite[1]), .dbus_wdata(bwd[1]), .dbus_pid(bpid[1]),
    .dbus_rsp_valid(rsp_v[1]), .dbus_rsp_rdata(rsp_rd[1]), .dbus_rsp_deny(rsp_d[1]),
    .data_mem_req(mreq[1]), .data_mem_we(mwe[1]), .data_mem_addr(maddr[1]),
    .data_mem_wdata(mwd[1]), .data_mem_rdata(mrd[1]));
  // one bank model per side
  sram_bank_model code_bank (.clk_sys(clk_sys), .req(mreq[0]), .addr(maddr[0]), .rdata(mrd[0]));
  sram_bank_model data_bank (.clk_sys(clk_sys), .req(mreq[1]), .addr(maddr[1]), .rdata(mrd[1]));
  // clock, 25 ns period
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // shared compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // register write, one strobe cycle
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_pid <= p;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wreg
  // register read, data only in the following cycle
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rreg
  // one access on bus b, judged at both pipeline stages
  task automatic acc(input int b, input logic [31:0] a, input logic w, input logic [2:0] p,
                     input logic deny, input logic [31:0] phys);
    @(posedge clk_sys);
    baddr[b] <= a;
    bwrite[b] <= w;
    bwd[b] <= ~a;
    bpid[b] <= p;
    bvalid[b] <= 1'b1;
    @(posedge clk_sys);
    bvalid[b] <= 1'b0;
    #1;
    chk(32'(mreq[b]), 32'(!deny));
    chk(32'(mwe[b]), 32'(w & !deny));
    if (!deny) chk(maddr[b], phys);
    if (!deny && w) chk(mwd[b], ~a);
    @(posedge clk_sys);
    #1;
    chk(32'(rsp_v[b]), 32'h1);
    chk(32'(rsp_d[b]), 32'(deny));
    chk(rsp_rd[b], (deny || w) ? 32'h0 : ~phys);
  endtask : acc
  // every register starts cleared, hole reads zero
  task automatic t_reset();
    for (int i = 0; i < 35; i++) rreg(8'(4 * i), 32'h0);
    rreg(8'hFC, 32'h0);
  endtask : t_reset
  // privileged identity, empty table refuses others
  task automatic t_priv();
    acc(1, 32'h3FFC2345, 1'b0, 3'h0, 1'b0, 32'h3FFC2345);
    acc(0, 32'h4009F00C, 1'b1, 3'h1, 1'b0, 32'h4009F00C);
    acc(1, 32'h3FFE0000, 1'b0, 3'h0, 1'b1, 32'h0);
    acc(1, 32'h3FFC0000, 1'b0, 3'h3, 1'b1, 32'h0);
  endtask : t_priv
  // translation, rights codes, lowest page wins, status clear
  task automatic t_xlat();
    wreg(8'h48, 32'h31, 3'h0);
    rreg(8'h48, 32'h31);
    acc(1, 32'h3FFC2345, 1'b0, 3'h3, 1'b0, 32'h3FFC4345);
    acc(1, 32'h3FFC2345, 1'b1, 3'h3, 1'b0, 32'h3FFC4345);
    acc(1, 32'h3FFC2345, 1'b0, 3'h4, 1'b1, 32'h0);
    rreg(8'h88, 32'h2);
    wreg(8'h88, 32'h2, 3'h5);
    rreg(8'h88, 32'h0);
    wreg(8'h54, 32'h11, 3'h1);
    acc(1, 32'h3FFC2345, 1'b0, 3'h3, 1'b0, 32'h3FFC4345);
    acc(1, 32'h3FFC2345, 1'b0, 3'h6, 1'b0, 32'h3FFCA345);
  endtask : t_xlat
  // configuration writes from unprivileged processes are dropped
  task automatic t_gate();
    wreg(8'h48, 32'h0, 3'h2);
    rreg(8'h48, 32'h31);
    wreg(8'h84, 32'h1, 3'h7);
    rreg(8'h84, 32'h0);
    wreg(8'h84, 32'h3, 3'h0);
    rreg(8'h84, 32'h0);
  endtask : t_gate
  // all three page sizes: layout, sixteenth page; tail region for 4 KB and 2 KB only
  task automatic t_psize();
    wreg(8'h40, 32'h1F, 3'h0);
    for (int s = 0; s < 3; s++) begin
      ps = 32'h2000 >> s;
      wreg(8'h84, 32'(s), 3'h0);
      rreg(8'h84, 32'(s));
      acc(1, 32'h3FFC0045 + ps, 1'b0, 3'h3, 1'b0, 32'h3FFC0045 + 2 * ps);
      acc(1, 32'h3FFC0004 + 15 * ps, 1'b0, 3'h2, 1'b0, 32'h3FFC0004);
      if (s > 0) begin
        acc(1, 32'h3FFC0000 + 16 * ps, 1'b0, 3'h3, 1'b1, 32'h0);
        acc(1, 32'h3FFDFFF0, 1'b1, 3'h1, 1'b0, 32'h3FFDFFF0);
      end
    end
  endtask : t_psize
  // code unit on the instruction bus, read only for processes 2 to 7
  task automatic t_code();
    wreg(8'h00, 32'h13, 3'h0);
    rreg(8'h00, 32'h13);
    acc(0, 32'h40086010, 1'b0, 3'h2, 1'b0, 32'h40080010);
    acc(0, 32'h40086010, 1'b1, 3'h2, 1'b1, 32'h0);
    acc(0, 32'h3FFC2345, 1'b0, 3'h0, 1'b1, 32'h0);
    // code bank with 4 KB pages: same entry, and its own tail region
    wreg(8'h80, 32'h1, 3'h0);
    acc(0, 32'h40083010, 1'b0, 3'h2, 1'b0, 32'h40080010);
    acc(0, 32'h40090000, 1'b0, 3'h2, 1'b1, 32'h0);
    rreg(8'h88, 32'h3);
  endtask : t_code
  // enable low freezes state, denial beats clear, reset in mid-run
  task automatic t_hold();
    @(posedge clk_sys);
    ce <= 1'b0;
    // a strobe while frozen must leave the selector alone
    wreg(8'h80, 32'h2, 3'h0);
    ce <= 1'b1;
    rreg(8'h80, 32'h1);
    // clear of both flags and a fresh data denial on the same edge
    @(posedge clk_sys);
    reg_addr <= 8'h88;
    reg_wdata <= 32'h3;
    reg_wr <= 1'b1;
    baddr[1] <= 32'h3FFE0000;
    bwrite[1] <= 1'b0;
    bpid[1] <= 3'h0;
    bvalid[1] <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    bvalid[1] <= 1'b0;
    rreg(8'h88, 32'h2);
    // one reset edge must bring every register back to zero
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    rreg(8'h00, 32'h0);
    rreg(8'h48, 32'h0);
    rreg(8'h84, 32'h0);
    rreg(8'h88, 32'h0);
  endtask : t_hold
  // verdict, single exit point
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_priv();
    t_xlat();
    t_gate();
    t_psize();
    t_code();
    t_hold();
    test_done();
  end
  // watchdog, well beyond the few hundred cycles needed
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
endmodule : internal_sram_page_mmu_tb
